/* logic/energy_accum_pkg.sv */
// constants shared by the energy accumulation and pulse output logic
package energy_accum_pkg;
  localparam int N_PHASES = 3;
  localparam int N_TYPES = 4;
  localparam int N_CHANNELS = 12;
  localparam int N_OUTPUTS = 4;
  localparam int N_ZX = 4;
  localparam int POWER_W = 32;
  localparam int INT_W = 42;
  localparam int USER_W = 45;
  localparam int HI_W = 32;
  localparam int LO_W = 13;
  localparam int LO_SHIFT = 19;
  localparam int INTERVAL_W = 13;
  localparam int ZERO_CROSS_SOURCE_SELECT_W = 2;
  localparam int READ_SEL_W = 5;
  localparam int SUM_W = 36;
  localparam int DTOF_W = 40;
  localparam int DEN_W = 16;
  localparam int WIDTH_COUNT_W = 20;
  localparam int TIMER_W = 24;
  localparam int ENERGY_SEL_W = 3;
  // energy type codes for the per-output energy select
  localparam logic [2:0] SEL_ACTIVE = 3'h0;
  localparam logic [2:0] SEL_REACTIVE = 3'h1;
  localparam logic [2:0] SEL_APPARENT = 3'h2;
  localparam logic [2:0] SEL_FUND_REACTIVE = 3'h3;
  // read select: bit 0 picks low word, upper bits pick channel (phase * 4 + type)
  localparam int READ_LO_BIT = 0;
  // timing
  localparam longint CLK_HZ = 25_000_000;
  localparam longint LOW_WIDTH_MS = 80;
  localparam longint LOW_WIDTH_CYCLES = (CLK_HZ * LOW_WIDTH_MS) / 1000;
  localparam int WIDTH_MASTER_CLOCK_INPUT_MULT = 6;
  // digital to frequency threshold per internal pulse
  localparam logic [31:0] DTOF_THRESHOLD = 32'h0010_0000;
endpackage : energy_accum_pkg

/* logic/pulse_link_if.sv */
// carries energy samples and settings from the accumulator to one pulse generator
`timescale 1ns/1ps
`default_nettype none
interface pulse_link_if;
  logic sample_tick;
  logic signed [energy_accum_pkg::SUM_W-1:0] energy;
  logic no_load;
  logic width_sel;
  logic [energy_accum_pkg::WIDTH_COUNT_W-1:0] width_count;
  logic [energy_accum_pkg::DEN_W-1:0] divider;
  logic disable_out;
  logic [energy_accum_pkg::TIMER_W-1:0] low_width;
  logic pulse_n;
  logic ready;
  modport src (
    output sample_tick, energy, no_load, width_sel, width_count, divider, disable_out,
    output low_width,
    input pulse_n, ready
  );
  modport sink (
    input sample_tick, energy, no_load, width_sel, width_count, divider, disable_out,
    input low_width,
    output pulse_n, ready
  );
endinterface : pulse_link_if
`default_nettype wire

/* logic/pulse_output_gen.sv */
// one digital to frequency converter with divider and pulse width shaping
`timescale 1ns/1ps
`default_nettype none
module pulse_output_gen (
  input wire logic core_clk,
  input wire logic reset,
  pulse_link_if.sink link
);
  logic signed [energy_accum_pkg::DTOF_W-1:0] acc_reg;
  logic [energy_accum_pkg::DEN_W-1:0] den_cnt_reg;
  logic [energy_accum_pkg::DEN_W-1:0] half_cnt_reg;
  logic [energy_accum_pkg::TIMER_W-1:0] timer_reg;
  logic pulse_n_reg;
  logic ready_reg;

  // threshold crossing gives one internal pulse
  logic signed [energy_accum_pkg::DTOF_W-1:0] acc_sum;
  logic signed [energy_accum_pkg::DTOF_W-1:0] thr;
  logic pos_fire;
  logic neg_fire;
  logic fire;
  assign thr = energy_accum_pkg::DTOF_W'(energy_accum_pkg::DTOF_THRESHOLD);
  assign acc_sum = acc_reg + energy_accum_pkg::DTOF_W'(link.energy);
  assign pos_fire = link.sample_tick && (acc_sum >= thr);
  assign neg_fire = link.sample_tick && (acc_sum <= -thr);
  assign fire = (pos_fire || neg_fire) && !link.no_load;

  // one output pulse after each group of divider internal pulses
  logic out_event;
  logic [energy_accum_pkg::DEN_W-1:0] den_inc;
  assign den_inc = den_cnt_reg + 16'h0001;
  assign out_event = fire && (den_inc >= link.divider);

  // release when the width timer runs out or half the divider has passed
  logic [energy_accum_pkg::TIMER_W-1:0] width_limit;
  logic [energy_accum_pkg::DEN_W-1:0] half_limit;
  logic timer_done;
  logic half_done;
  logic hold_low;
  logic release_high;
  assign width_limit = link.width_sel ?
    energy_accum_pkg::TIMER_W'(link.width_count * energy_accum_pkg::WIDTH_MASTER_CLOCK_INPUT_MULT) :
    link.low_width;
  // rounding up gives 50% for even and (1 + 1/den) x 50% for odd dividers
  assign half_limit = energy_accum_pkg::DEN_W'((17'(link.divider) + 17'h1) >> 1);
  // the falling edge is already the first low cycle, so compare one count ahead
  assign timer_done = (timer_reg + 24'h000001) >= width_limit;
  assign half_done = half_cnt_reg >= half_limit;
  assign hold_low = link.width_sel && link.no_load;
  // with width select 0 a running pulse simply finishes under no load
  assign release_high = !pulse_n_reg && !hold_low && (timer_done || half_done);

  // accumulator and divider counter
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc_reg <= '0;
      den_cnt_reg <= '0;
    end else begin
      if (pos_fire && !link.no_load) begin
        acc_reg <= acc_sum - thr;
      end else if (neg_fire && !link.no_load) begin
        acc_reg <= acc_sum + thr;
      end else if (link.sample_tick) begin
        acc_reg <= acc_sum;
      end
      if (out_event) begin
        den_cnt_reg <= '0;
      end else if (fire) begin
        den_cnt_reg <= den_inc;
      end
    end
  end

  // active low pulse shaping; disable forces the pin high
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pulse_n_reg <= 1'b1;
      timer_reg <= '0;
      half_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= out_event && !link.disable_out;
      if (link.disable_out) begin
        pulse_n_reg <= 1'b1;
      end else if (out_event) begin
        pulse_n_reg <= 1'b0;
        timer_reg <= '0;
        half_cnt_reg <= '0;
      end else if (release_high) begin
        pulse_n_reg <= 1'b1;
      end else if (!pulse_n_reg) begin
        if (!timer_done) begin
          timer_reg <= timer_reg + 24'h000001;
        end
        if (fire) begin
          half_cnt_reg <= half_cnt_reg + 16'h0001;
        end
      end
    end
  end

  assign link.pulse_n = pulse_n_reg;
  assign link.ready = ready_reg;
endmodule : pulse_output_gen
`default_nettype wire

/* logic/energy_accum_pulse_output.sv */
// per-phase energy accumulation into user registers and four pulse outputs
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - strobe after interval count plus one time-base units
// - timer base select 0 counts DSP samples
// - timer base select 1 counts half line cycles from zero crossings
// - interval count is 13 bits, up to 8192 units
// - half-cycle events come from the selected zero-crossing source
// - strobe adds to user register, or overwrites when load bit set
// - internal accumulator clears after transfer and resumes from zero
// - signed 42-bit internal accumulator per phase and type at sample rate
// - signed 45-bit user accumulator per phase and type, updated on strobes
// - user value read as upper 32-bit word and lower 13-bit word
// - lower 13 bits are left-justified, shifted up by 19
// - clear-on-read enable zeroes the word of a user register that is read
// - clearing the upper word leaves the lower bits untouched
// - overwrite mode refreshes lower bits at every strobe
// - four pulse outputs at rates proportional to their energy
// - width select 0: 80 ms low, or 50% style duty at high rates
// - width select 1: low width is width count times six clocks, or 50% style duty at high rates
// - width select 0: entering no load finishes the pulse then high
// - width select 1: entering no load holds a low pulse low
// - 3-bit energy select per output, code 000 is total active
// - 3-bit phase mask per output, 111 sums all three phases
// - one output pulse per divider-count internal pulses, divider 2..65535
// - disabled output stays high and raises no ready flag
module energy_accum_pulse_output #(
  parameter logic [23:0] LOW_WIDTH_CYCLES = 24'(energy_accum_pkg::LOW_WIDTH_CYCLES)
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sample_tick,
  input wire logic [energy_accum_pkg::N_ZX-1:0] zero_cross_event,
  input wire logic [energy_accum_pkg::ZERO_CROSS_SOURCE_SELECT_W-1:0] zero_cross_source_select,
  input wire logic energy_timer_base_select,
  input wire logic [energy_accum_pkg::INTERVAL_W-1:0] energy_interval_count,
  input wire logic energy_load_not_add,
  input wire logic clear_on_read_enable,
  input wire logic [energy_accum_pkg::N_CHANNELS*energy_accum_pkg::POWER_W-1:0] phase_power,
  input wire logic [energy_accum_pkg::N_CHANNELS-1:0] channel_no_load,
  input wire logic read_strobe,
  input wire logic [energy_accum_pkg::READ_SEL_W-1:0] read_select,
  input wire logic [energy_accum_pkg::N_OUTPUTS-1:0] pulse_width_select,
  input wire logic [energy_accum_pkg::WIDTH_COUNT_W-1:0] pulse_width_count,
  input wire logic [energy_accum_pkg::N_OUTPUTS*energy_accum_pkg::DEN_W-1:0] pulse_divider_count,
  input wire logic [energy_accum_pkg::N_OUTPUTS*3-1:0] pulse_energy_select,
  input wire logic [energy_accum_pkg::N_OUTPUTS*3-1:0] pulse_phase_mask,
  input wire logic [energy_accum_pkg::N_OUTPUTS-1:0] pulse_output_disable,
  output logic [31:0] read_data,
  output logic energy_ready_strobe,
  output logic [energy_accum_pkg::N_OUTPUTS-1:0] pulse_output_n,
  output logic [energy_accum_pkg::N_OUTPUTS-1:0] pulse_ready
);
  localparam int NC = energy_accum_pkg::N_CHANNELS;

  // sign-extend one channel's power sample to the 45-bit user accumulator width
  function automatic logic signed [energy_accum_pkg::USER_W-1:0] power_of(
    input logic [energy_accum_pkg::N_CHANNELS*energy_accum_pkg::POWER_W-1:0] bus,
    input int idx
  );
    logic signed [energy_accum_pkg::POWER_W-1:0] s;
    s = bus[idx*energy_accum_pkg::POWER_W +: energy_accum_pkg::POWER_W];
    return energy_accum_pkg::USER_W'(s);
  endfunction : power_of

  // interval timer on the selected time base
  logic [energy_accum_pkg::INTERVAL_W-1:0] interval_cnt_reg;
  logic strobe_reg;
  logic zx_tick;
  logic base_tick;
  logic interval_done;
  assign zx_tick = zero_cross_event[zero_cross_source_select];
  assign base_tick = energy_timer_base_select ? zx_tick : sample_tick;
  // >= so that lowering the interval mid-period cannot run the counter through a wrap
  assign interval_done = base_tick && (interval_cnt_reg >= energy_interval_count);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      interval_cnt_reg <= '0;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= interval_done;
      if (interval_done) begin
        interval_cnt_reg <= '0;
      end else if (base_tick) begin
        interval_cnt_reg <= interval_cnt_reg + 13'h1;
      end
    end
  end

  // read decode; an index beyond the last channel reads zero
  logic [3:0] read_index;
  logic read_lo;
  logic read_valid;
  assign read_index = read_select[energy_accum_pkg::READ_SEL_W-1:1];
  assign read_lo = read_select[energy_accum_pkg::READ_LO_BIT];
  assign read_valid = read_index < 4'(NC);

  logic signed [energy_accum_pkg::INT_W-1:0] int_acc_reg [NC];
  logic signed [energy_accum_pkg::USER_W-1:0] user_acc_reg [NC];
  logic [31:0] hi_word [NC];
  logic [31:0] lo_word [NC];

  // per-channel internal and user accumulators
  for (genvar c = 0; c < NC; c++) begin : g_chan
    logic signed [energy_accum_pkg::INT_W-1:0] sample_add;
    logic signed [energy_accum_pkg::INT_W-1:0] int_next;
    logic signed [energy_accum_pkg::USER_W-1:0] base_val;
    logic signed [energy_accum_pkg::USER_W-1:0] user_next;
    logic hit;
    logic clr_hi;
    logic clr_lo;
    // no-load channels feed zero energy
    assign sample_add = channel_no_load[c] ? '0 :
      energy_accum_pkg::INT_W'(power_of(phase_power, c));
    assign hit = read_strobe && read_valid && (read_index == 4'(c)) && clear_on_read_enable;
    assign clr_hi = hit && !read_lo;
    assign clr_lo = hit && read_lo;
    // the clear is applied first so a same-cycle transfer still lands
    assign base_val = clr_hi ?
      {32'h0000_0000, user_acc_reg[c][energy_accum_pkg::LO_W-1:0]} :
      (clr_lo ? {user_acc_reg[c][energy_accum_pkg::USER_W-1:energy_accum_pkg::LO_W], 13'h0} :
      user_acc_reg[c]);
    assign user_next = energy_load_not_add ? energy_accum_pkg::USER_W'(int_acc_reg[c]) :
      base_val + energy_accum_pkg::USER_W'(int_acc_reg[c]);
    // after transfer, restart from zero plus any sample of this cycle
    assign int_next = strobe_reg ? (sample_tick ? sample_add : '0) :
      (sample_tick ? int_acc_reg[c] + sample_add : int_acc_reg[c]);
    assign hi_word[c] = user_acc_reg[c][energy_accum_pkg::USER_W-1:energy_accum_pkg::LO_W];
    assign lo_word[c] = {user_acc_reg[c][energy_accum_pkg::LO_W-1:0], 19'h0};

    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        int_acc_reg[c] <= '0;
        user_acc_reg[c] <= '0;
      end else begin
        int_acc_reg[c] <= int_next;
        if (strobe_reg) begin
          user_acc_reg[c] <= user_next;
        end else begin
          user_acc_reg[c] <= base_val;
        end
      end
    end
  end

  // read data is captured on the strobe, before any clear takes effect
  logic [31:0] read_data_reg;
  logic [31:0] read_word;
  assign read_word = !read_valid ? 32'h0000_0000 :
    (read_lo ? lo_word[read_index] : hi_word[read_index]);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      read_data_reg <= '0;
    end else if (read_strobe) begin
      read_data_reg <= read_word;
    end
  end

  // pulse generators: energy type and phase selection per output
  logic [energy_accum_pkg::N_OUTPUTS-1:0] pulse_n_w;
  logic [energy_accum_pkg::N_OUTPUTS-1:0] ready_w;
  for (genvar o = 0; o < energy_accum_pkg::N_OUTPUTS; o++) begin : g_out
    pulse_link_if link ();
    logic [2:0] esel;
    logic [2:0] pmask;
    logic type_ok;
    logic [1:0] etype;
    logic signed [energy_accum_pkg::SUM_W-1:0] sum;
    logic all_no_load;
    assign esel = pulse_energy_select[o*3 +: 3];
    assign pmask = pulse_phase_mask[o*3 +: 3];
    // codes above fundamental reactive select nothing
    assign type_ok = esel <= energy_accum_pkg::SEL_FUND_REACTIVE;
    assign etype = esel[1:0];
    // channel index is phase * 4 + type
    assign sum = (pmask[0] && type_ok && !channel_no_load[{2'h0, etype}] ?
        energy_accum_pkg::SUM_W'(power_of(phase_power, {2'h0, etype})) : '0) +
      (pmask[1] && type_ok && !channel_no_load[{2'h1, etype}] ?
        energy_accum_pkg::SUM_W'(power_of(phase_power, {2'h1, etype})) : '0) +
      (pmask[2] && type_ok && !channel_no_load[{2'h2, etype}] ?
        energy_accum_pkg::SUM_W'(power_of(phase_power, {2'h2, etype})) : '0);
    // the output is in no load only when every included phase is
    assign all_no_load = (!pmask[0] || channel_no_load[{2'h0, etype}]) &&
      (!pmask[1] || channel_no_load[{2'h1, etype}]) &&
      (!pmask[2] || channel_no_load[{2'h2, etype}]) && (pmask != 3'h0);
    assign link.sample_tick = sample_tick;
    assign link.energy = sum;
    assign link.no_load = all_no_load;
    assign link.width_sel = pulse_width_select[o];
    assign link.width_count = pulse_width_count;
    assign link.divider = pulse_divider_count[o*energy_accum_pkg::DEN_W +: energy_accum_pkg::DEN_W];
    assign link.disable_out = pulse_output_disable[o];
    assign link.low_width = LOW_WIDTH_CYCLES;
    assign pulse_n_w[o] = link.pulse_n;
    assign ready_w[o] = link.ready;

    pulse_output_gen u_gen (
      .core_clk(core_clk),
      .reset(reset),
      .link(link.sink)
    );
  end

  // outputs come straight from flip-flops (pulse flops live in the generators)
  assign read_data = read_data_reg;
  assign energy_ready_strobe = strobe_reg;
  assign pulse_output_n = pulse_n_w;
  assign pulse_ready = ready_w;
endmodule : energy_accum_pulse_output
`default_nettype wire

/* verif/energy_accum_pulse_output_assertions.sv */
// concurrent checks on the energy accumulation and pulse output ports
`timescale 1ns/1ps
`default_nettype none
module energy_accum_checker #(
  parameter logic [23:0] LOW_WIDTH_CYCLES = 24'h32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sample_tick,
  input wire logic [3:0] zero_cross_event,
  input wire logic [1:0] zero_cross_source_select,
  input wire logic energy_timer_base_select,
  input wire logic [12:0] energy_interval_count,
  input wire logic clear_on_read_enable,
  input wire logic [11:0] channel_no_load,
  input wire logic read_strobe,
  input wire logic [4:0] read_select,
  input wire logic [3:0] pulse_width_select,
  input wire logic [19:0] pulse_width_count,
  input wire logic [3:0] pulse_output_disable,
  input wire logic [31:0] read_data,
  input wire logic energy_ready_strobe,
  input wire logic [3:0] pulse_output_n,
  input wire logic [3:0] pulse_ready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic zero_cross_source_select_ev;
  logic [23:0] low_cnt [4];
  assign zero_cross_source_select_ev = zero_cross_event[zero_cross_source_select];
  // low-time counters restart on ready, so a retriggered pulse is timed afresh
  always_ff @(posedge core_clk or posedge reset) begin
    for (int k = 0; k < 4; k++) begin
      if (reset) low_cnt[k] <= 24'h0;
      else low_cnt[k] <= (pulse_output_n[k] || pulse_ready[k]) ? 24'h0 : low_cnt[k] + 24'h1;
    end
  end
  // a read with clear, no transfer landing in that cycle, followed at once by the same read
  sequence hi_clear_rd;
    read_strobe && clear_on_read_enable && !read_select[0] && !energy_ready_strobe;
  endsequence
  sequence same_rd;
    read_strobe && $stable(read_select);
  endsequence
  strobe_single_a: assert property (
    energy_ready_strobe && !sample_tick && !(|zero_cross_event) |=> !energy_ready_strobe)
    else $error("energy strobe longer than one cycle");
  sample_base_a: assert property (
    energy_ready_strobe && !energy_timer_base_select |-> $past(sample_tick))
    else $error("strobe without a sample tick");
  zx_base_a: assert property (
    energy_ready_strobe && energy_timer_base_select |-> $past(zero_cross_source_select_ev))
    else $error("strobe without selected zero crossing");
  interval_zero_a: assert property (
    sample_tick && !energy_timer_base_select && energy_interval_count == 13'h0
    |=> energy_ready_strobe) else $error("no strobe for interval zero");
  lo_align_a: assert property (
    read_strobe && read_select[0] |=> read_data[18:0] == 19'h0)
    else $error("lower bits not left aligned");
  hi_clear_a: assert property (
    hi_clear_rd ##1 same_rd |=> read_data == 32'h0) else $error("upper word not cleared");
  for (genvar k = 0; k < 4; k++) begin : g_out
    disable_quiet_a: assert property (
      pulse_output_disable[k] && $past(pulse_output_disable[k])
      |-> pulse_output_n[k] && !pulse_ready[k]) else $error("disabled output active");
    ready_start_a: assert property (
      $fell(pulse_output_n[k]) |-> pulse_ready[k]) else $error("pulse start without ready");
    width_short_a: assert property (
      !pulse_output_n[k] && pulse_width_select[k] && channel_no_load == 12'h0 &&
      $past(channel_no_load) == 12'h0
      |-> low_cnt[k] + 1 < pulse_width_count * 6) else $error("counted pulse too long");
    width_long_a: assert property (
      !pulse_output_n[k] && !pulse_width_select[k] |-> low_cnt[k] + 1 < LOW_WIDTH_CYCLES)
      else $error("fixed pulse too long");
  end
endmodule : energy_accum_checker
bind energy_accum_pulse_output energy_accum_checker
  #(.LOW_WIDTH_CYCLES(LOW_WIDTH_CYCLES)) chk_inst (.*);
`default_nettype wire

/* verif/pulse_counter_model.sv */
// external meter pulse counter: counts low pulses and times each one
`timescale 1ns/1ps
`default_nettype none
module pulse_counter_model (
  input wire logic core_clk,
  input wire logic clear,
  input wire logic [3:0] pulse_n,
  output var int pulses [4],
  output var int width [4]
);
  int run [4];
  // sees only the lines, never the ready flags
  always @(posedge core_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (clear) begin
        pulses[k] <= 0;
        run[k] <= 0;
      end else if (!pulse_n[k]) begin
        run[k] <= run[k] + 1;
        if (run[k] == 0) pulses[k] <= pulses[k] + 1;
      end else if (run[k] != 0) begin
        width[k] <= run[k];
        run[k] <= 0;
      end
    end
  end
endmodule : pulse_counter_model
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the energy accumulation and pulse output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
  logic core_clk = 1'b0, reset = 1'b1, sample_tick = 1'b0, energy_timer_base_select = 1'b0;
  logic energy_load_not_add = 1'b0, clear_on_read_enable = 1'b0, read_strobe = 1'b0;
  logic [3:0] zero_cross_event = 4'h0, pulse_width_select = 4'h0, pulse_output_disable = 4'h0;
  logic [1:0] zero_cross_source_select = 2'h0;
  logic [12:0] energy_interval_count = 13'h0;
  logic [383:0] phase_power = '0, pw;
  logic [11:0] channel_no_load = 12'h0, pulse_energy_select = 12'h0, pulse_phase_mask = 12'h0;
  logic [4:0] read_select = 5'h0;
  logic [19:0] pulse_width_count = 20'h0;
  logic [63:0] pulse_divider_count = 64'h0;
  logic [31:0] read_data, want, seed = 32'h6fa8;
  logic energy_ready_strobe, rd_pend = 1'b0, cnt_clr = 1'b0;
  logic [3:0] pulse_output_n, pulse_ready;
  logic [31:0] exp_q [$];
  logic signed [44:0] p0, p11, e;
  int num_errors = 0, checked = 0, strobes = 0;
  int pulses [4], width [4], readies [4];
  energy_accum_pulse_output #(.LOW_WIDTH_CYCLES(24'h32)) DUT (.*);
  pulse_counter_model counter (.core_clk(core_clk), .clear(cnt_clr), .pulse_n(pulse_output_n),
    .pulses(pulses), .width(width));
  always #20 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // read answers land one cycle after the request edge
  always @(posedge core_clk) begin
    if (rd_pend) begin
      want = exp_q.pop_front();
      `CHK(read_data, want)
    end
    rd_pend <= read_strobe;
    if (energy_ready_strobe === 1'b1) strobes++;
    for (int k = 0; k < 4; k++) if (pulse_ready[k] === 1'b1) readies[k]++;
  end
  task automatic idle(input int n);
    read_strobe <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask : idle
  // sample and zero-crossing events, each a one-cycle pulse and then a quiet gap
  task automatic ev(input logic st, input logic [3:0] zx, input int n, input int gap);
    repeat (n) begin
      sample_tick <= st;
      zero_cross_event <= zx;
      @(posedge core_clk);
      sample_tick <= 1'b0;
      zero_cross_event <= 4'h0;
      repeat (gap) @(posedge core_clk);
    end
  endtask : ev
  // strobe stays up so back-to-back reads need no idle cycle
  task automatic rd(input logic [4:0] sel, input logic [31:0] exp);
    read_strobe <= 1'b1;
    read_select <= sel;
    exp_q.push_back(exp);
    @(posedge core_clk);
  endtask : rd
  // settings change under reset so each scenario starts from empty accumulators
  task automatic restart;
    reset <= 1'b1;
    strobes = 0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
  endtask : restart
  task automatic close_out;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  initial begin
    for (int c = 0; c < 12; c++) begin
      seed = lfsr(seed);
      pw[c*32 +: 32] = seed;
    end
    p0 = $signed(pw[31:0]);
    p11 = $signed(pw[383:352]);
    phase_power <= pw;
    energy_interval_count <= 13'h2;
    channel_no_load <= 12'h002;
    restart();
    ev(1'b1, 4'h0, 6, 3);
    idle(3);
    `CHK(strobes, 2)
    e = p0 * 6;
    rd(5'h00, e[44:13]);
    rd(5'h01, {e[12:0], 19'h0});
    e = p11 * 6;
    rd(5'h16, e[44:13]);
    rd(5'h02, 32'h0);
    rd(5'h1a, 32'h0);
    idle(3);
    energy_load_not_add <= 1'b1;
    restart();
    ev(1'b1, 4'h0, 6, 3);
    idle(3);
    e = p0 * 3;
    rd(5'h00, e[44:13]);
    rd(5'h01, {e[12:0], 19'h0});
    idle(3);
    energy_load_not_add <= 1'b0;
    energy_interval_count <= 13'h0;
    clear_on_read_enable <= 1'b1;
    restart();
    ev(1'b1, 4'h0, 1, 3);
    e = p0;
    rd(5'h00, e[44:13]);
    rd(5'h00, 32'h0);
    clear_on_read_enable <= 1'b0;
    rd(5'h01, {e[12:0], 19'h0});
    idle(2);
    ev(1'b1, 4'h0, 1, 3);
    e = $signed({32'h0, e[12:0]}) + p0;
    rd(5'h00, e[44:13]);
    idle(2);
    energy_timer_base_select <= 1'b1;
    zero_cross_source_select <= 2'h2;
    energy_interval_count <= 13'h1;
    restart();
    ev(1'b1, 4'hb, 4, 3);
    `CHK(strobes, 0)
    ev(1'b0, 4'h4, 4, 3);
    idle(2);
    `CHK(strobes, 2)
    energy_timer_base_select <= 1'b0;
    // phases b and c carry half a threshold each, so output 3 halves if its mask drops one
    phase_power <= {96'h0, 32'h0008_0000, 96'h0, 32'h0008_0000, 96'h0, 32'h0010_0000};
    pulse_divider_count <= {16'h3, 16'h2, 16'h2, 16'h2};
    pulse_energy_select <= {3'h0, 3'h4, 3'h0, 3'h0};
    pulse_phase_mask <= {3'h6, 3'h1, 3'h1, 3'h1};
    pulse_output_disable <= 4'h2;
    pulse_width_select <= 4'h1;
    pulse_width_count <= 20'h2;
    channel_no_load <= 12'h0;
    cnt_clr <= 1'b1;
    restart();
    cnt_clr <= 1'b0;
    readies = '{default: 0};
    ev(1'b1, 4'h0, 8, 39);
    idle(100);
    `CHK(pulses[0], 4)
    `CHK(readies[0], 4)
    `CHK(width[0], 12)
    `CHK(pulses[1], 0)
    `CHK(readies[1], 0)
    `CHK(pulses[2], 0)
    `CHK(pulses[3], 2)
    `CHK(width[3], 50)
    `CHK(pulse_output_n, 4'hf)
    `CHK(pulse_ready, 4'h0)
    // no load while low: counted width holds on output 0, fixed width ends on output 3
    pulse_width_count <= 20'h14;
    ev(1'b1, 4'h0, 2, 3);
    channel_no_load <= 12'h111;
    idle(150);
    `CHK(pulse_output_n[0], 1'b0)
    `CHK(pulse_output_n[3], 1'b1)
    channel_no_load <= 12'h0;
    idle(2);
    `CHK(pulse_output_n[0], 1'b1)
    close_out();
  end
  // hang guard, far beyond the roughly 720 cycles the scenarios need
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
